/* File: eic_top.sv */
// integration sequencer, counters and register file of the light sensor core
`timescale 1ns/1ps
`default_nettype none

`include "eic_params.svh"

// Behaviour
// RULE_01: command bit 5 selects external timing
// RULE_02: first strobe starts single-diode integration
// RULE_03: next strobe stops the running integration
// RULE_04: strobe ends integration, starts new one
// RULE_05: sequential: strobes start diode one, then two
// RULE_06: third strobe ends diode two, restarts one
// RULE_07: cycle count follows window, 16-bit counter
// RULE_08: host keeps window under 65,535 periods
// RULE_09: oscillator identical in both timing modes
// RULE_10: host spaces strobes by bus clock cycles
// RULE_11: result readable at offsets 0x04, 0x05
// RULE_12: cycle count readable at 0x06, 0x07
// RULE_13: host picks window multiple of flicker
// RULE_14: host removes infrared arithmetically
// RULE_15: result and count latched together
module eic_top
   import eic_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // register port from the serial slave
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output var  logic [7:0]  reg_rdata_out,
   // analog front end
   input  wire logic [15:0] scaling_resistor_in,
   input  wire logic        visible_ir_photodiode_in,
   input  wire logic        ir_photodiode_in,
   // status
   output var  logic        integrating_out,
   output var  logic        ir_photodiode_active_out,
   output var  logic        result_ready_out
);

   eic_osc_if     osc_if ();
   eic_state_type state;
   eic_state_type next_state;
   logic [7:0]    command_control;
   logic [15:0]   conversion_result;
   logic [15:0]   cycle_count;
   logic [15:0]   data_acc;
   logic [15:0]   cycle_acc;
   logic          sync_strobe;
   logic          ext_mode;
   logic          ext_mode_prev;
   logic          window_end;
   logic          restart;
   logic          int_done;
   logic          diode_pulse;
   eic_mode_type  mode;
   logic [1:0]    width_sel;
   logic [15:0]   int_last;

   // ==========================================================
   // command decode
   assign mode      = eic_mode_type'(command_control[`EIC_CMD_MODE_LSB +: 2]);
   assign width_sel = command_control[`EIC_CMD_WIDTH_LSB +: 2];
   // RULE_01 timing mode select
   assign ext_mode  = command_control[`EIC_CMD_EXT_BIT];

   // write of a one to the sync bit with the timing bit also set is a strobe; the bit itself never stores
   assign sync_strobe = reg_wr_in && (reg_addr_in == `EIC_OFS_COMMAND) &&
                        reg_wdata_in[`EIC_CMD_SYNC_BIT] && reg_wdata_in[`EIC_CMD_EXT_BIT];

   // internal mode ends a window after 2^n oscillator periods, n = 4, 8, 12, 16
   always_comb begin
      case (width_sel)
         2'b00:   int_last = 16'hffff;
         2'b01:   int_last = 16'h0fff;
         2'b10:   int_last = 16'h00ff;
         default: int_last = 16'h000f;
      endcase
   end
   assign int_done = !ext_mode && (state != eic_idle) && osc_if.tick && (cycle_acc == int_last);

   // a strobe closes whatever window is open, internal windows close themselves
   assign window_end = (state != eic_idle) && (ext_mode ? sync_strobe : int_done);
   // leaving or entering external mode drops the running window
   assign restart    = (ext_mode != ext_mode_prev);

   // ==========================================================
   // oscillator enable divider
   assign osc_if.upper_range = command_control[`EIC_CMD_RANGE_LSB + 1];
   assign osc_if.scaling_resistor_kohm   = scaling_resistor_in;

   eic_osc_div u_osc (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .osc_if   (osc_if)
   );

   // ==========================================================
   // command register, sync bit reads back as zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         command_control <= `EIC_CMD_RESET;
         ext_mode_prev   <= 1'b0;
      end else begin
         ext_mode_prev <= ext_mode;
         if (reg_wr_in && (reg_addr_in == `EIC_OFS_COMMAND)) begin
            command_control <= reg_wdata_in & ~(8'h01 << `EIC_CMD_SYNC_BIT);
         end
      end
   end

   // ==========================================================
   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         eic_idle: begin
            // RULE_02 first strobe opens the window
            if (!restart && (ext_mode ? sync_strobe : 1'b1)) begin
               next_state = (mode == second_diode_only_mode) ? eic_integ_second : eic_integ_first;
            end
         end
         eic_integ_first: begin
            // RULE_05 second strobe moves to the infrared diode
            if (window_end && (mode == sequential_dual_diode_mode)) begin
               next_state = eic_integ_second;
            end
         end
         eic_integ_second: begin
            // RULE_06 third strobe returns to the first diode
            if (window_end && (mode == sequential_dual_diode_mode)) begin
               next_state = eic_integ_first;
            end
         end
         default: next_state = eic_idle;
      endcase
      if (restart) begin
         next_state = eic_idle;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= eic_idle;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // accumulators for photodiode events and oscillator periods
   assign diode_pulse = (state == eic_integ_second) ? ir_photodiode_in : visible_ir_photodiode_in;

   // RULE_03 RULE_04 stop and restart at once
   // strobe clears both accumulators so the new window starts from zero
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         data_acc  <= 16'h0000;
         cycle_acc <= 16'h0000;
      end else if (restart || window_end || (state == eic_idle)) begin
         data_acc  <= 16'h0000;
         cycle_acc <= 16'h0000;
      end else begin
         if (diode_pulse) begin
            data_acc <= data_acc + 16'h0001;
         end
         // RULE_07 counter wraps past 65,535; the host must avoid that
         // RULE_08 no saturation, overflow is the host's concern
         if (osc_if.tick) begin
            cycle_acc <= cycle_acc + 16'h0001;
         end
      end
   end

   // ==========================================================
   // result capture at each window end
   // RULE_15 data and count latched in one edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         conversion_result        <= `EIC_RESULT_RESET;
         cycle_count              <= `EIC_RESULT_RESET;
         ir_photodiode_active_out <= 1'b0;
         result_ready_out         <= 1'b0;
      end else if (window_end) begin
         conversion_result        <= data_acc + {15'h0000, diode_pulse};
         // internal windows report the full 2^n periods including the last tick; for n = 16 the count wraps to zero
         cycle_count              <= cycle_acc + {15'h0000, osc_if.tick};
         ir_photodiode_active_out <= (state == eic_integ_second);
         result_ready_out         <= 1'b1;
      end else begin
         result_ready_out         <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         integrating_out <= 1'b0;
      end else begin
         integrating_out <= (next_state != eic_idle);
      end
   end

   // ==========================================================
   // register read, one cycle after the address is presented
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         case (reg_addr_in)
            `EIC_OFS_COMMAND:  reg_rdata_out <= command_control;
            // RULE_11 result bytes
            `EIC_OFS_DATA_LO:  reg_rdata_out <= conversion_result[7:0];
            `EIC_OFS_DATA_HI:  reg_rdata_out <= conversion_result[15:8];
            // RULE_12 cycle count bytes
            `EIC_OFS_COUNT_LO: reg_rdata_out <= cycle_count[7:0];
            `EIC_OFS_COUNT_HI: reg_rdata_out <= cycle_count[15:8];
            default:           reg_rdata_out <= 8'h00;
         endcase
      end
   end

endmodule : eic_top

`default_nettype wire

/* File: eic_params.svh */
// constants for the external sync integration control block
`ifndef EIC_PARAMS_SVH
`define EIC_PARAMS_SVH

// ==========================================================
// register offsets
`define EIC_OFS_COMMAND     8'h00
`define EIC_OFS_DATA_LO     8'h04
`define EIC_OFS_DATA_HI     8'h05
`define EIC_OFS_COUNT_LO    8'h06
`define EIC_OFS_COUNT_HI    8'h07

// ==========================================================
// command_control field positions and reset value
`define EIC_CMD_WIDTH_LSB   0
`define EIC_CMD_RANGE_LSB   2
`define EIC_CMD_SYNC_BIT    4
`define EIC_CMD_EXT_BIT     5
`define EIC_CMD_MODE_LSB    6
`define EIC_CMD_RESET       8'h00

// ==========================================================
// oscillator timing and result reset value
`define EIC_CLK_HZ          64'd100000000
`define EIC_OSC_LOW_HZ      64'd327000
`define EIC_OSC_HIGH_HZ     64'd655000
`define EIC_REF_KOHM        64'd100
`define EIC_RESULT_RESET    16'h0000

`endif

/* File: eic_pkg.sv */
// types and shared arithmetic for the external sync integration control block
`include "eic_params.svh"

package eic_pkg;

   // ==========================================================
   // integration sequencer states, gray along the usual path
   typedef enum logic [1:0] {
      eic_idle         = 2'b00,
      eic_integ_first  = 2'b01,
      eic_integ_second = 2'b11
   } eic_state_type;

   // ==========================================================
   // diode selection modes
   typedef enum logic [1:0] {
      first_diode_only_mode      = 2'b00,
      second_diode_only_mode     = 2'b01,
      sequential_dual_diode_mode = 2'b10,
      eic_mode_spare             = 2'b11
   } eic_mode_type;

   // ==========================================================
   // system clocks per oscillator period, inverse to the frequency
   function automatic logic [15:0] eic_osc_period(input logic upper, input logic [15:0] scaling_resistor_kohm);
      logic [63:0] num;
      logic [63:0] den;
      logic [63:0] quo;
      num = `EIC_CLK_HZ * {48'h0, scaling_resistor_kohm};
      den = (upper ? `EIC_OSC_HIGH_HZ : `EIC_OSC_LOW_HZ) * `EIC_REF_KOHM;
      quo = num / den;
      if (quo == 64'h0) begin
         quo = 64'h1;                    // never faster than the system clock
      end else if (quo > 64'h0000_ffff) begin
         quo = 64'h0000_ffff;
      end
      eic_osc_period = quo[15:0];
   endfunction : eic_osc_period

endpackage : eic_pkg

/* File: eic_osc_if.sv */
// link between the sequencer and the oscillator enable divider
`timescale 1ns/1ps
`default_nettype none

interface eic_osc_if;
   logic        upper_range;   // lux range three or four selected
   logic [15:0] scaling_resistor_kohm;     // scaling resistor value in kilo-ohm
   logic        tick;          // one-cycle oscillator period pulse

   modport seq (output upper_range, output scaling_resistor_kohm, input tick);
   modport osc (input upper_range, input scaling_resistor_kohm, output tick);
endinterface : eic_osc_if

`default_nettype wire

/* File: eic_osc_div.sv */
// internal oscillator model: one enable pulse per oscillator period
`timescale 1ns/1ps
`default_nettype none

module eic_osc_div
   import eic_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // sequencer side
   eic_osc_if.osc    osc_if
);

   logic [15:0] period;
   logic [15:0] count;

   // ==========================================================
   // period follows range and resistor the same way in both timing modes
   // RULE_09 same oscillator both modes
   assign period = eic_osc_period(osc_if.upper_range, osc_if.scaling_resistor_kohm);

   // free-running divider; a range change applies to the running period at once, as count is compared with the new period
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count       <= 16'h0000;
         osc_if.tick <= 1'b0;
      end else if (count >= period - 16'h0001) begin
         count       <= 16'h0000;
         osc_if.tick <= 1'b1;
      end else begin
         count       <= count + 16'h0001;
         osc_if.tick <= 1'b0;
      end
   end

endmodule : eic_osc_div

`default_nettype wire

/* File: eic_top_chk.sv */
// port assertions for the integration control top
`timescale 1ns/1ps
`default_nettype none
module eic_top_chk (
   // clock and reset
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   // register port and status
   input wire logic       reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       integrating_out,
   input wire logic       ir_photodiode_active_out,
   input wire logic       result_ready_out
);
   logic       cmd_w;
   logic       stb_w;
   logic       ext_q;
   logic [1:0] mode_q;
   assign cmd_w = reg_wr_in && (reg_addr_in == 8'h00);
   assign stb_w = cmd_w && (reg_wdata_in[5:4] == 2'b11);
   // shadow of timing and mode bits, only the writes show them here
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_q  <= 1'b0;
         mode_q <= 2'b00;
      end else if (cmd_w) begin
         ext_q  <= reg_wdata_in[5];
         mode_q <= reg_wdata_in[7:6];
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_start; ext_q && stb_w |=> integrating_out; endproperty
   a_start: assert property (p_start) else $error("strobe did not open a window");
   property p_end; ext_q && stb_w && integrating_out |-> ##[1:2] result_ready_out; endproperty
   a_end: assert property (p_end) else $error("closing strobe gave no result");
   property p_nores; ext_q && stb_w && !integrating_out |=> !result_ready_out [*2]; endproperty
   a_nores: assert property (p_nores) else $error("opening strobe gave a result");
   property p_cause; ext_q && $past(ext_q, 3) && result_ready_out |-> $past(stb_w) || $past(stb_w, 2); endproperty
   a_cause: assert property (p_cause) else $error("result without strobe");
   property p_unmap; !(reg_addr_in inside {8'h00, [8'h04:8'h07]}) |=> reg_rdata_out == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_irhold; $changed(ir_photodiode_active_out) |-> result_ready_out; endproperty
   a_irhold: assert property (p_irhold) else $error("diode flag moved alone");
   property p_sel; ext_q && result_ready_out && mode_q != 2'b10 |-> ir_photodiode_active_out == (mode_q == 2'b01); endproperty
   a_sel: assert property (p_sel) else $error("wrong diode latched");
   // the cycle after timing turns external the old window is dropped on purpose
   property p_hold; ext_q && $past(ext_q) && integrating_out && !cmd_w |=> integrating_out; endproperty
   a_hold: assert property (p_hold) else $error("window closed without strobe");
endmodule : eic_top_chk
`default_nettype wire

/* File: eic_host_model.sv */
// host side model driving the register port
`timescale 1ns/1ps
`default_nettype none
module eic_host_model (
   // clock
   input  wire logic       clk_in,
   // register port
   output var  logic       reg_wr_out,
   output var  logic [7:0] reg_addr_out,
   output var  logic [7:0] reg_wdata_out,
   input  wire logic [7:0] reg_rdata_in
);
   initial begin
      reg_wr_out    = 1'b0;
      reg_addr_out  = 8'hff;
      reg_wdata_out = 8'h00;
   end
   // timing bit and strobe spacing by cycles
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_wr_out    <= 1'b1;
      reg_addr_out  <= a;
      reg_wdata_out <= d;
      @(posedge clk_in);
      reg_wr_out    <= 1'b0;
      reg_wdata_out <= ~d; // stale data is not left on the bus
   endtask : write_reg
   // read data is registered, taken one edge after the address
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      @(posedge clk_in);
      #1 d = reg_rdata_in;
   endtask : read_reg
endmodule : eic_host_model
`default_nettype wire

/* File: test_ext_sync_integration_control.sv */
// self-checking bench for the integration control top
`timescale 1ns/1ps
`default_nettype none
module test_ext_sync_integration_control;
   import eic_pkg::*;
   typedef struct { logic [1:0] m; int nv; int ni; logic [15:0] res; logic ir; } eic_row_type;
   localparam int WIN = 40;
   // host picks window length
   // strobe to strobe: three idle clocks, WIN stimulus clocks, two write clocks
   localparam int SPAN = WIN + 5;
   // two 16-bit reads sit inside the next window in sequential runs
   localparam int READS = 8;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic vis = 1'b0;
   logic irp = 1'b0;
   logic [15:0] scaling_resistor = 16'h0001;
   logic wr, integ, ir_act, ready;
   logic [7:0] addr, wdata, rdata, b;
   logic [15:0] v;
   int failures = 0;
   int num_checks = 0;
   int i, j;
   eic_row_type rows [3] = '{'{2'b00, 5, 2, 16'h5, 1'b0}, '{2'b01, 5, 2, 16'h2, 1'b1}, '{2'b11, 5, 2, 16'h5, 1'b0}};
   always #5 clk_in = ~clk_in;
   eic_host_model host_u (.clk_in(clk_in), .reg_wr_out(wr), .reg_addr_out(addr), .reg_wdata_out(wdata),
      .reg_rdata_in(rdata));
   eic_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .scaling_resistor_in(scaling_resistor), .visible_ir_photodiode_in(vis),
      .ir_photodiode_in(irp), .integrating_out(integ), .ir_photodiode_active_out(ir_act),
      .result_ready_out(ready));
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic rd16(input logic [7:0] a, output logic [15:0] r);
      logic [7:0] lo, hi;
      host_u.read_reg(a, lo);
      host_u.read_reg(a + 8'h01, hi);
      r = {hi, lo};
   endtask : rd16
   // upper range with unit resistor gives one tick per clock
   task automatic strobe(input logic [1:0] m, input logic exp_ready);
      logic seen;
      seen = 1'b0;
      host_u.write_reg(8'h00, {m, 6'h38});
      for (int k = 0; k < 3; k++) begin
         #1 if (ready === 1'b1) seen = 1'b1;
         @(posedge clk_in);
      end
      // look after the edge has settled, not in its own time step
      #1;
      check("ready", {15'h0, exp_ready}, {15'h0, seen});
      check("open", 16'h1, {15'h0, integ});
   endtask : strobe
   // nv pulses on the first diode and ni on the infrared one
   task automatic pulses(input int nv, input int ni);
      for (int k = 0; k < WIN; k++) begin
         @(posedge clk_in);
         vis <= (k % 2 == 1) && (k < 2 * nv);
         irp <= (k % 2 == 1) && (k < 2 * ni);
      end
   endtask : pulses
   task automatic results(input logic [15:0] res, input logic ir, input logic [15:0] cnt);
      rd16(8'h04, v);
      check("result", res, v);
      rd16(8'h06, v);
      check("count", cnt, v);
      check("diode", {15'h0, ir}, {15'h0, ir_act});
   endtask : results
   task automatic complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   // watchdog far beyond the few hundred cycles of the run
   initial begin
      #200000;
      failures++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // reset values, unmapped and read-only places
      host_u.write_reg(8'h05, 8'h5a);
      for (i = 0; i < 8; i++) begin
         host_u.read_reg(i[7:0], b);
         check("reset_reg", 16'h0, {8'h0, b});
      end
      host_u.write_reg(8'h00, 8'ha8);
      host_u.read_reg(8'h00, b);
      check("command", 16'h00a8, {8'h0, b});
      $display("test reset done");
      // ordinary rows: one full window in each single-diode mode
      for (i = 0; i < 3; i++) begin
         host_u.write_reg(8'h00, 8'h00);
         host_u.write_reg(8'h00, {rows[i].m, 6'h28});
         strobe(rows[i].m, 1'b0);
         pulses(rows[i].nv, rows[i].ni);
         strobe(rows[i].m, 1'b1);
         results(rows[i].res, rows[i].ir, 16'(SPAN));
         $display("test row %0d done", i);
      end
      // sequential mode alternates diodes and restarts on the third strobe
      host_u.write_reg(8'h00, 8'h00);
      host_u.write_reg(8'h00, 8'ha8);
      strobe(2'b10, 1'b0);
      for (j = 0; j < 3; j++) begin
         pulses(3, 6);
         strobe(2'b10, 1'b1);
         results((j % 2 == 1) ? 16'h6 : 16'h3, j % 2 == 1, (j == 0) ? 16'(SPAN) : 16'(SPAN + READS));
      end
      $display("test sequential done");
      // resistor 2 in the upper range slows the oscillator to one tick per three clocks
      @(posedge clk_in);
      scaling_resistor <= 16'h0002;
      host_u.write_reg(8'h00, 8'h00);
      host_u.write_reg(8'h00, 8'h28);
      strobe(2'b00, 1'b0);
      pulses(0, 0);
      strobe(2'b00, 1'b1);
      results(16'h0, 1'b0, 16'(SPAN / 3));
      @(posedge clk_in);
      scaling_resistor <= 16'h0001;
      $display("test resistor done");
      // internal timing with width code 11 closes a window every sixteen ticks by itself
      host_u.write_reg(8'h00, 8'h0f);
      repeat (40) @(posedge clk_in);
      rd16(8'h06, v);
      check("internal", 16'h0010, v);
      $display("test internal done");
      // a reset in mid run clears outputs, command and the latched count
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      check("reset_out", 16'h0, {rdata, 5'h0, integ, ir_act, ready});
      rst_n_in <= 1'b1;
      host_u.read_reg(8'h00, b);
      check("reset_cmd", 16'h0, {8'h0, b});
      rd16(8'h06, v);
      check("reset_count", 16'h0, v);
      $display("test reset again done");
      complete_run();
   end
endmodule : test_ext_sync_integration_control
bind eic_top eic_top_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .integrating_out(integrating_out), .ir_photodiode_active_out(ir_photodiode_active_out),
   .result_ready_out(result_ready_out));
`default_nettype wire
